// *** core/dma_pkg.sv ***
/*
 * dma_pkg: register map, field positions, reset values, state codes and
 * bus carriers of the multi-channel transfer engine.
 * assumes: one clock domain; APB register port; a simple ready/error master port.
 */
package dma_pkg;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam logic [11:0] OFF_STATUS  = 12'h000;
	localparam logic [11:0] OFF_CLEAR   = 12'h004;
	localparam logic [11:0] OFF_CH_BASE = 12'h008;
	localparam int          CH_SHIFT    = 4;
	localparam logic [3:0]  OFF_CFG     = 4'h0;
	localparam logic [3:0]  OFF_COUNT   = 4'h4;
	localparam logic [3:0]  OFF_PADDR   = 4'h8;
	localparam logic [3:0]  OFF_MADDR   = 4'hC;

	// ---------------------------------------------------------------
	// channel_config fields
	// ---------------------------------------------------------------
	localparam int CFG_EN      = 0;
	localparam int CFG_DONE_IE = 1;
	localparam int CFG_HALF_IE = 2;
	localparam int CFG_ERR_IE  = 3;
	localparam int CFG_DIR     = 4;
	localparam int CFG_CIRCULAR_ENABLE    = 5;
	localparam int CFG_PERIPH_ADDR_INCREMENT    = 6;
	localparam int CFG_MEM_ADDR_INCREMENT    = 7;
	localparam int CFG_PSIZE   = 8;
	localparam int CFG_MSIZE   = 10;
	localparam int CFG_PRIO    = 12;
	localparam int CFG_M2M     = 14;
	localparam int CFG_SEL     = 16;
	localparam int SEL_W       = 6;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_MASK  = 32'h003F_7FFF;

	// ---------------------------------------------------------------
	// status / clear nibble per channel
	// ---------------------------------------------------------------
	localparam int FLG_GLB  = 0;
	localparam int FLG_DONE = 1;
	localparam int FLG_HALF = 2;
	localparam int FLG_ERR  = 3;
	localparam int FLG_W    = 4;

	// ---------------------------------------------------------------
	// item sizes and request map
	// ---------------------------------------------------------------
	localparam logic [1:0]  SIZE_8  = 2'h0;
	localparam logic [1:0]  SIZE_16 = 2'h1;
	localparam logic [1:0]  SIZE_32 = 2'h2;
	localparam int          NUM_REQ = 64;
	localparam logic [63:0] REQ_VALID_MASK = 64'h0000_43FF_FFF9_E07F;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_READ  = 4'h2,
		ST_WRITE = 4'h4,
		ST_GAP   = 4'h8
	} eng_state_t;

	typedef struct packed {
		logic [31:0] cfg;
		logic [15:0] count;
		logic [15:0] count_init;
		logic [31:0] paddr_base;
		logic [31:0] maddr_base;
		logic [31:0] paddr_cur;
		logic [31:0] maddr_cur;
		logic        half_flag;
		logic        done_flag;
		logic        err_flag;
	} chan_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic        req;
		logic        write;
		logic [31:0] addr;
		logic [1:0]  size;
		logic [31:0] wdata;
	} mbus_req_t;

	typedef struct packed {
		logic        ready;
		logic        err;
		logic [31:0] rdata;
	} mbus_rsp_t;

endpackage : dma_pkg

// *** core/dma_engine.sv ***
/*
 * dma_engine: multi-channel transfer engine with APB register slave and one
 * system bus master port.
 * assumes: peripheral requests come from logic on i_ref_clk; the bus fabric
 * answers a master request with ready (and err for a reserved region).
 */
// Chosen here: the APB slave port and the placing of the registers.
// Behaviour
// R1: write data always carries all 32 bits; size follows destination width.
// R2: narrower source is zero-extended to destination width, then replicated.
// R3: source at least destination width and below 32 bits is replicated.
// R4: increment on: side address grows by 1, 2 or 4 per item.
// R5: increment off: every item uses the side's base address.
// R6: address registers readable but write-protected while channel enabled.
// R7: acyclic channel stops at count zero; software re-arms while disabled.
// R8: circular channel reloads count and addresses at zero and continues.
// R9: two-bit priority per channel, 3 highest, arbitrates between channels.
// R10: interrupt enable bit 1 passes its interrupt, 0 suppresses it.
// R11: software sets a reserved select value for memory-to-memory use.
// R12: writing 1 to a clear bit clears its flag; 0 does nothing.
// R13: memory-to-memory runs items back to back, no request needed.
// R14: otherwise direction 1 memory to peripheral, 0 reverse; one item per request.
// R15: while enabled only the enable bit of the config is writable.
// R16: reserved region access sets error, clears enable, halts channel.
// R17: half flag sets when half of the items are moved.
// R18: complete flag sets when all items are moved.
// R19: bus error response sets the channel error flag.
// R20: per-channel level interrupt from enabled flags.
// R21: select field picks one of 35 requests; other values reserved.
// R22: software clears pending flags before enabling a channel.
// R23: global flag is OR of three flags; clearing it clears all.
`timescale 1ns/1ps
module dma_engine #(
	parameter int NCH = 5
) (
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_sys_rst,
	input  wire dma_pkg::apb_req_t            i_apb,
	output      dma_pkg::apb_rsp_t            o_apb,
	input  wire logic [dma_pkg::NUM_REQ-1:0]  i_periph_req,
	output      logic [dma_pkg::NUM_REQ-1:0]  o_req_ack,
	output      dma_pkg::mbus_req_t           o_mbus,
	input  wire dma_pkg::mbus_rsp_t           i_mbus,
	output      logic [NCH-1:0]               o_chan_irq
);

	localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

	typedef struct packed {
		dma_pkg::eng_state_t          st;
		logic [CW-1:0]                cur;
		logic [31:0]                  item;
		logic                         pready;
		logic                         pslverr;
		logic [31:0]                  prdata;
		dma_pkg::chan_t [NCH-1:0]     ch;
	} state_t;

	state_t                 s_reg;
	state_t                 s_next;
	dma_pkg::mbus_req_t     mbus;
	logic [dma_pkg::NUM_REQ-1:0] req_ack;
	logic                   acc;
	logic                   wr_go;
	logic [11:0]            rel;
	logic [CW-1:0]          dec_idx;
	logic                   ch_hit;
	logic [CW:0]            pk;
	dma_pkg::chan_t         cc;
	logic                   src_mem;
	logic [1:0]             src_size;
	logic [1:0]             dst_size;
	logic [31:0]            src_addr;
	logic [31:0]            dst_addr;
	logic [15:0]            cnt_dec;
	logic                   wr_done;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [31:0] size_bytes(input logic [1:0] sz);
		if (sz == dma_pkg::SIZE_8) begin
			return 32'h0000_0001;
		end else if (sz == dma_pkg::SIZE_16) begin
			return 32'h0000_0002;
		end
		return 32'h0000_0004;
	endfunction : size_bytes

	function automatic logic [31:0] item_mask(input logic [31:0] d, input logic [1:0] sz);
		if (sz == dma_pkg::SIZE_8) begin
			return {24'h00_0000, d[7:0]};
		end else if (sz == dma_pkg::SIZE_16) begin
			return {16'h0000, d[15:0]};
		end
		return d;
	endfunction : item_mask

	// zero-extended item replicated at the wider of the two widths
	function automatic logic [31:0] pack(input logic [31:0] d, input logic [1:0] ss,
		input logic [1:0] ds);
		logic [1:0] w;
		w = (ss < ds) ? ds : ss;                                     // [R2] [R3]
		if (w == dma_pkg::SIZE_8) begin
			return {4{d[7:0]}};                                      // [R3]
		end else if (w == dma_pkg::SIZE_16) begin
			return {2{d[15:0]}};                                     // [R2] [R3]
		end
		return d;                                                    // [R1] [R2]
	endfunction : pack

	function automatic logic [dma_pkg::FLG_W-1:0] flag_nib(input dma_pkg::chan_t c);
		return {c.err_flag, c.half_flag, c.done_flag,
			c.err_flag | c.half_flag | c.done_flag};                 // [R23]
	endfunction : flag_nib

	function automatic logic eligible(input dma_pkg::chan_t c,
		input logic [dma_pkg::NUM_REQ-1:0] rq);
		logic [dma_pkg::SEL_W-1:0] sel;
		sel = c.cfg[dma_pkg::CFG_SEL +: dma_pkg::SEL_W];
		return c.cfg[dma_pkg::CFG_EN] && (c.count != 16'h0000)      // [R7]
			&& (c.cfg[dma_pkg::CFG_M2M]                              // [R13]
			|| (rq[sel] && dma_pkg::REQ_VALID_MASK[sel]));          // [R14] [R21]
	endfunction : eligible

	// highest priority wins, lower index on a tie
	function automatic logic [CW:0] pick(input dma_pkg::chan_t [NCH-1:0] c,
		input logic [dma_pkg::NUM_REQ-1:0] rq);
		logic          found;
		logic [CW-1:0] idx;
		logic [1:0]    best;
		found = 1'b0;
		idx = '0;
		best = 2'h0;
		for (int i = 0; i < NCH; i++) begin
			if (eligible(c[i], rq) && (!found
				|| c[i].cfg[dma_pkg::CFG_PRIO +: 2] > best)) begin     // [R9]
				found = 1'b1;
				idx = CW'(i);
				best = c[i].cfg[dma_pkg::CFG_PRIO +: 2];
			end
		end
		return {found, idx};
	endfunction : pick

	// ---------------------------------------------------------------
	// decode and current channel view
	// ---------------------------------------------------------------
	assign acc = i_apb.psel & i_apb.penable;
	assign wr_go = acc & s_reg.pready & i_apb.pwrite;
	assign rel = i_apb.paddr - dma_pkg::OFF_CH_BASE;
	assign dec_idx = rel[CW+dma_pkg::CH_SHIFT-1:dma_pkg::CH_SHIFT];
	assign ch_hit = (i_apb.paddr >= dma_pkg::OFF_CH_BASE) && (i_apb.paddr[1:0] == 2'h0)
		&& ((rel >> dma_pkg::CH_SHIFT) < 12'(NCH));
	assign pk = pick(s_reg.ch, i_periph_req);
	assign cc = s_reg.ch[s_reg.cur];
	assign src_mem = ~cc.cfg[dma_pkg::CFG_M2M] & cc.cfg[dma_pkg::CFG_DIR];      // [R13] [R14]
	assign src_size = src_mem ? cc.cfg[dma_pkg::CFG_MSIZE +: 2] : cc.cfg[dma_pkg::CFG_PSIZE +: 2];
	assign dst_size = src_mem ? cc.cfg[dma_pkg::CFG_PSIZE +: 2] : cc.cfg[dma_pkg::CFG_MSIZE +: 2];
	assign src_addr = src_mem ? cc.maddr_cur : cc.paddr_cur;
	assign dst_addr = src_mem ? cc.paddr_cur : cc.maddr_cur;
	assign cnt_dec = cc.count - 16'h0001;
	assign wr_done = (s_reg.st == dma_pkg::ST_WRITE) & i_mbus.ready & ~i_mbus.err;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		mbus = '0;
		req_ack = '0;
		s_next.pready = acc & ~s_reg.pready;
		// register read and slave error
		if (acc && !s_reg.pready) begin
			s_next.prdata = 32'h0000_0000;
			s_next.pslverr = 1'b0;
			if (i_apb.paddr == dma_pkg::OFF_STATUS) begin
				for (int c = 0; c < NCH; c++) begin
					s_next.prdata[c*dma_pkg::FLG_W +: dma_pkg::FLG_W] = flag_nib(s_reg.ch[c]);
				end
			end else if (i_apb.paddr == dma_pkg::OFF_CLEAR) begin
				s_next.prdata = 32'h0000_0000;
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_CFG) begin
				s_next.prdata = s_reg.ch[dec_idx].cfg;
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_COUNT) begin
				s_next.prdata = {16'h0000, s_reg.ch[dec_idx].count};
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_PADDR) begin
				s_next.prdata = s_reg.ch[dec_idx].paddr_base;                  // [R6]
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_MADDR) begin
				s_next.prdata = s_reg.ch[dec_idx].maddr_base;                  // [R6]
			end else begin
				s_next.pslverr = 1'b1;
			end
		end
		// register write
		if (wr_go) begin
			if (i_apb.paddr == dma_pkg::OFF_CLEAR) begin
				for (int c = 0; c < NCH; c++) begin
					if (i_apb.pwdata[c*dma_pkg::FLG_W+dma_pkg::FLG_GLB]) begin      // [R23]
						s_next.ch[c].done_flag = 1'b0;
						s_next.ch[c].half_flag = 1'b0;
						s_next.ch[c].err_flag = 1'b0;
					end
					if (i_apb.pwdata[c*dma_pkg::FLG_W+dma_pkg::FLG_DONE]) begin     // [R12]
						s_next.ch[c].done_flag = 1'b0;
					end
					if (i_apb.pwdata[c*dma_pkg::FLG_W+dma_pkg::FLG_HALF]) begin     // [R12]
						s_next.ch[c].half_flag = 1'b0;
					end
					if (i_apb.pwdata[c*dma_pkg::FLG_W+dma_pkg::FLG_ERR]) begin      // [R12]
						s_next.ch[c].err_flag = 1'b0;
					end
				end
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_CFG) begin
				if (s_reg.ch[dec_idx].cfg[dma_pkg::CFG_EN]) begin
					s_next.ch[dec_idx].cfg[dma_pkg::CFG_EN] = i_apb.pwdata[dma_pkg::CFG_EN]; // [R15]
				end else begin
					s_next.ch[dec_idx].cfg = i_apb.pwdata & dma_pkg::CFG_MASK;
					s_next.ch[dec_idx].paddr_cur = s_reg.ch[dec_idx].paddr_base;
					s_next.ch[dec_idx].maddr_cur = s_reg.ch[dec_idx].maddr_base;
				end
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_COUNT) begin
				if (!s_reg.ch[dec_idx].cfg[dma_pkg::CFG_EN]) begin               // [R7]
					s_next.ch[dec_idx].count = i_apb.pwdata[15:0];
					s_next.ch[dec_idx].count_init = i_apb.pwdata[15:0];
				end
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_PADDR) begin
				if (!s_reg.ch[dec_idx].cfg[dma_pkg::CFG_EN]) begin               // [R6]
					s_next.ch[dec_idx].paddr_base = i_apb.pwdata;
					s_next.ch[dec_idx].paddr_cur = i_apb.pwdata;
				end
			end else if (ch_hit && rel[3:0] == dma_pkg::OFF_MADDR) begin
				if (!s_reg.ch[dec_idx].cfg[dma_pkg::CFG_EN]) begin               // [R6]
					s_next.ch[dec_idx].maddr_base = i_apb.pwdata;
					s_next.ch[dec_idx].maddr_cur = i_apb.pwdata;
				end
			end
		end
		// transfer engine; flag sets come after clears so a set wins
		case (s_reg.st)
			dma_pkg::ST_IDLE: begin
				if (pk[CW]) begin                                                // [R9]
					s_next.cur = pk[CW-1:0];
					s_next.st = dma_pkg::ST_READ;
				end
			end
			dma_pkg::ST_READ: begin
				mbus.req = 1'b1;
				mbus.addr = src_addr;
				mbus.size = src_size;
				if (i_mbus.ready) begin
					if (i_mbus.err) begin
						s_next.ch[s_reg.cur].err_flag = 1'b1;                        // [R19]
						s_next.ch[s_reg.cur].cfg[dma_pkg::CFG_EN] = 1'b0;            // [R16]
						s_next.st = dma_pkg::ST_GAP;
					end else begin
						s_next.item = item_mask(i_mbus.rdata >> {src_addr[1:0], 3'h0}, src_size);
						s_next.st = dma_pkg::ST_WRITE;
					end
				end
			end
			dma_pkg::ST_WRITE: begin
				mbus.req = 1'b1;
				mbus.write = 1'b1;
				mbus.addr = dst_addr;
				mbus.size = dst_size;                                            // [R1]
				mbus.wdata = pack(s_reg.item, src_size, dst_size);               // [R1]
				if (i_mbus.ready) begin
					s_next.st = dma_pkg::ST_GAP;
					if (i_mbus.err) begin
						s_next.ch[s_reg.cur].err_flag = 1'b1;                        // [R19]
						s_next.ch[s_reg.cur].cfg[dma_pkg::CFG_EN] = 1'b0;            // [R16]
					end else begin
						s_next.ch[s_reg.cur].count = cnt_dec;
						if (cc.cfg[dma_pkg::CFG_PERIPH_ADDR_INCREMENT]) begin                         // [R4] [R5]
							s_next.ch[s_reg.cur].paddr_cur = cc.paddr_cur
								+ size_bytes(cc.cfg[dma_pkg::CFG_PSIZE +: 2]);
						end
						if (cc.cfg[dma_pkg::CFG_MEM_ADDR_INCREMENT]) begin                         // [R4] [R5]
							s_next.ch[s_reg.cur].maddr_cur = cc.maddr_cur
								+ size_bytes(cc.cfg[dma_pkg::CFG_MSIZE +: 2]);
						end
						if (cnt_dec == (cc.count_init >> 1)) begin
							s_next.ch[s_reg.cur].half_flag = 1'b1;                   // [R17]
						end
						if (cnt_dec == 16'h0000) begin
							s_next.ch[s_reg.cur].done_flag = 1'b1;                   // [R18]
							if (cc.cfg[dma_pkg::CFG_CIRCULAR_ENABLE]) begin                     // [R8]
								s_next.ch[s_reg.cur].count = cc.count_init;
								s_next.ch[s_reg.cur].paddr_cur = cc.paddr_base;
								s_next.ch[s_reg.cur].maddr_cur = cc.maddr_base;
							end
						end
						if (!cc.cfg[dma_pkg::CFG_M2M]) begin                         // [R14]
							req_ack[cc.cfg[dma_pkg::CFG_SEL +: dma_pkg::SEL_W]] = 1'b1;
						end
					end
				end
			end
			dma_pkg::ST_GAP: begin
				s_next.st = dma_pkg::ST_IDLE;
			end
			default: begin
				s_next.st = dma_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			s_reg <= '0;
			s_reg.st <= dma_pkg::ST_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign o_apb.prdata = s_reg.prdata;
	assign o_apb.pready = s_reg.pready;
	assign o_apb.pslverr = s_reg.pslverr;
	assign o_mbus = mbus;
	assign o_req_ack = req_ack;

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_irq
			assign o_chan_irq[g] =
				(s_reg.ch[g].done_flag & s_reg.ch[g].cfg[dma_pkg::CFG_DONE_IE])   // [R10] [R20]
				| (s_reg.ch[g].half_flag & s_reg.ch[g].cfg[dma_pkg::CFG_HALF_IE])
				| (s_reg.ch[g].err_flag & s_reg.ch[g].cfg[dma_pkg::CFG_ERR_IE]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	dma_pkg::chan_t c0;
	logic [31:0]    maddr_exp0;
	logic           on0;
	logic           wr_lk;
	assign c0 = s_reg.ch[0];
	assign maddr_exp0 = c0.maddr_cur + size_bytes(c0.cfg[dma_pkg::CFG_MSIZE +: 2]);
	assign on0 = wr_done && (s_reg.cur == '0);
	assign wr_lk = wr_go && ch_hit && s_reg.ch[dec_idx].cfg[dma_pkg::CFG_EN];
	AST_SIZE_DST: assert property (o_mbus.write |-> o_mbus.size == dst_size) // [R1]
		else $error("write size differs from destination width");
	AST_ZERO_EXT: assert property (o_mbus.write && src_size == dma_pkg::SIZE_8 // [R2]
		&& dst_size == dma_pkg::SIZE_16 |-> o_mbus.wdata[15:8] == 8'h00
		&& o_mbus.wdata[31:16] == o_mbus.wdata[15:0])
		else $error("byte to halfword not padded and replicated");
	AST_REPLICATE: assert property (o_mbus.write && src_size == dma_pkg::SIZE_8 // [R3]
		&& dst_size == dma_pkg::SIZE_8 |-> o_mbus.wdata == {4{s_reg.item[7:0]}})
		else $error("byte item not replicated");
	AST_MEM_ADDR_INCREMENT: assert property (on0 && c0.cfg[dma_pkg::CFG_MEM_ADDR_INCREMENT] && !c0.cfg[dma_pkg::CFG_CIRCULAR_ENABLE] // [R4]
		|=> c0.maddr_cur == $past(maddr_exp0))
		else $error("memory address did not advance by item width");
	AST_FIXED: assert property (cc.cfg[dma_pkg::CFG_EN] && !cc.cfg[dma_pkg::CFG_PERIPH_ADDR_INCREMENT] // [R5]
		|-> cc.paddr_cur == cc.paddr_base)
		else $error("fixed peripheral address moved");
	AST_ADDR_LOCK: assert property (wr_lk && rel[3:0] == dma_pkg::OFF_PADDR // [R6]
		|=> s_reg.ch[$past(dec_idx)].paddr_base == $past(s_reg.ch[dec_idx].paddr_base))
		else $error("address written while enabled");
	AST_STOP: assert property (s_reg.st == dma_pkg::ST_READ |-> cc.count != 16'h0000) // [R7]
		else $error("transfer started with zero count");
	AST_CIRCULAR_ENABLE: assert property (wr_done && cc.cfg[dma_pkg::CFG_CIRCULAR_ENABLE] // [R8]
		&& cc.count == 16'h0001 |=> cc.count == cc.count_init && cc.maddr_cur == cc.maddr_base)
		else $error("circular reload missing");
	AST_CLEAR: assert property (wr_go && i_apb.paddr == dma_pkg::OFF_CLEAR // [R12]
		&& i_apb.pwdata[dma_pkg::FLG_DONE] && !on0 |=> !c0.done_flag)
		else $error("complete flag not cleared");
	AST_CFG_LOCK: assert property (wr_lk && rel[3:0] == dma_pkg::OFF_CFG // [R15]
		|=> (s_reg.ch[$past(dec_idx)].cfg >> 1) == ($past(s_reg.ch[dec_idx].cfg) >> 1))
		else $error("config changed while enabled");
	AST_ERR_HALT: assert property (o_mbus.req && i_mbus.ready && i_mbus.err // [R16]
		|=> !cc.cfg[dma_pkg::CFG_EN] ##1 s_reg.st == dma_pkg::ST_IDLE)
		else $error("channel not halted on error");
	AST_ERR_FLAG: assert property (o_mbus.req && i_mbus.ready && i_mbus.err |=> cc.err_flag) // [R19]
		else $error("error flag not set");
	AST_DONE: assert property (on0 && c0.count == 16'h0001 |=> c0.done_flag) // [R18]
		else $error("complete flag not set");
	AST_HALF: assert property (on0 && (c0.count - 16'h0001) == (c0.count_init >> 1) // [R17]
		|=> c0.half_flag)
		else $error("half flag not set");
	AST_IRQ: assert property ($rose(c0.done_flag) && c0.cfg[dma_pkg::CFG_DONE_IE] // [R20]
		|-> o_chan_irq[0])
		else $error("interrupt not raised");
	AST_MASK: assert property (cc.cfg[dma_pkg::CFG_DONE_IE +: 3] == 3'h0 // [R10]
		|-> !o_chan_irq[s_reg.cur])
		else $error("masked interrupt raised");

	COV_M2M: cover property (on0 && c0.cfg[dma_pkg::CFG_M2M] ##[4:40] on0);
	COV_CIRCULAR_ENABLE: cover property (wr_done && cc.cfg[dma_pkg::CFG_CIRCULAR_ENABLE] && cc.count == 16'h0001);
	COV_ERR: cover property (o_mbus.req && i_mbus.ready && i_mbus.err);
	COV_PERIPH: cover property (|o_req_ack);

endmodule : dma_engine

// *** sim/mem_model.sv ***
/* mem_model: memory and peripheral side of the engine master port.
 assumes: requests held until ready; 0xE region is reserved. */
`timescale 1ns/1ps
module mem_model (
	input  wire logic               i_ref_clk,
	input  wire logic               i_sys_rst,
	input  wire dma_pkg::mbus_req_t i_req,
	output      dma_pkg::mbus_rsp_t o_rsp
);
	logic [1:0] wait_reg;
	logic       ready_reg;
	function automatic logic [31:0] pat(input logic [31:0] a);
		return {4{a[9:2]}} ^ 32'h3CA5_5AC3;
	endfunction : pat
	// ----------------------------
	// stall 1..4 cycles by address
	// ----------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst || !i_req.req || ready_reg) begin
			wait_reg  <= 2'h0;
			ready_reg <= 1'b0;
		end else begin
			wait_reg  <= wait_reg + 2'h1;
			ready_reg <= (wait_reg == i_req.addr[3:2]);
		end
	end
	assign o_rsp.ready = ready_reg;
	assign o_rsp.err   = ready_reg && (i_req.addr[31:28] == 4'hE);
	// data inverted outside the answer cycle
	assign o_rsp.rdata = ready_reg ? pat(i_req.addr) : ~pat(i_req.addr);
endmodule : mem_model

// *** sim/tb_top.sv ***
/* tb_top: self-checking bench of dma_engine with a memory model.
 assumes: dma_pkg and mem_model compiled first. */
`timescale 1ns/1ps
module tb_top;
	logic               clk, rst, want, ack_d, slverr;
	dma_pkg::apb_req_t  apb;
	dma_pkg::apb_rsp_t  apb_r;
	dma_pkg::mbus_req_t mb;
	dma_pkg::mbus_rsp_t mb_r;
	logic [63:0]        preq, ack;
	logic [4:0]         irq;
	logic [31:0]        seed, rd;
	logic [65:0]        expq[$];
	int                 error_cnt, num_checks, cyc, n;
	dma_engine #(.NCH(5)) dma_engine_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_apb(apb),
		.o_apb(apb_r), .i_periph_req(preq), .o_req_ack(ack), .o_mbus(mb), .i_mbus(mb_r),
		.o_chan_irq(irq));
	mem_model mem_model_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_req(mb), .o_rsp(mb_r));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic logic [11:0] ca(input logic [2:0] c, input logic [3:0] o);
		return dma_pkg::OFF_CH_BASE + {5'h0, c, 4'h0} + {8'h0, o};
	endfunction : ca
	task automatic chk(input string nm, input logic [65:0] got, input logic [65:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	// ----------------------------
	// apb master and channel setup
	// ----------------------------
	task automatic apb_x(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		apb <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk);
		apb.penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (apb_r.pready !== 1'b1 && k < 50);
		rd = apb_r.prdata;
		slverr = apb_r.pslverr;
		apb <= '0;
	endtask : apb_x
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb_x(1'b0, a, 32'h0);
		chk("read", rd, e);
	endtask : rdc
	task automatic run(input logic [2:0] c, input logic [31:0] cfg, pb, mbs, input logic [15:0] cnt);
		logic        sp;
		logic [31:0] sa, da, it, wd, sb, db, w;
		sp = cfg[14] | !cfg[4];
		sb = 32'h1 << (sp ? cfg[9:8] : cfg[11:10]);
		db = 32'h1 << (sp ? cfg[11:10] : cfg[9:8]);
		w = (sb > db) ? sb : db;
		apb_x(1'b1, 12'h004, 32'h000F_FFFF);
		apb_x(1'b1, ca(c, 4'h4), {16'h0, cnt});
		apb_x(1'b1, ca(c, 4'h8), pb);
		apb_x(1'b1, ca(c, 4'hC), mbs);
		apb_x(1'b1, ca(c, 4'h0), cfg);
		for (int i = 0; i < cnt * (cfg[5] ? 2 : 1); i++) begin
			sa = (sp ? pb : mbs) + ((sp ? cfg[6] : cfg[7]) ? (i % cnt) * sb : 32'h0);
			da = (sp ? mbs : pb) + ((sp ? cfg[7] : cfg[6]) ? (i % cnt) * db : 32'h0);
			it = (mem_model_inst.pat(sa) >> (8 * sa[1:0])) & ~(32'hFFFF_FFFF << (8 * sb));
			wd = it | (it << (8 * w));
			wd = wd | (wd << (16 * w));
			expq.push_back({sp ? cfg[11:10] : cfg[9:8], da, wd});
		end
	endtask : run
	task automatic drain;
		n = 0;
		while (expq.size() != 0 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk("left", expq.size(), 66'h0);
		repeat (8) @(posedge clk);
	endtask : drain
	always @(posedge clk) begin
		if (mb.req && mb.write && mb_r.ready && !mb_r.err) begin
			if (expq.size() == 0) chk("extra", 66'h1, 66'h0);
			else chk("write", {mb.size, mb.addr, mb.wdata}, expq.pop_front());
		end
		ack_d <= |ack;
		preq <= (want && expq.size() != 0 && !(|ack) && !ack_d) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0;
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------------------
	// scenarios
	// ----------------------------
	initial begin
		rst = 1'b1; apb = '0; want = 1'b0; preq = '0; ack_d = 1'b0;
		seed = 32'h158F_D5AE; error_cnt = 0; num_checks = 0; cyc = 0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(ca(3'h4, 4'h0), dma_pkg::CFG_RESET);
		apb_x(1'b0, 12'hFFC, 32'h0);
		chk("slverr", slverr, 1'b1);
		run(3'h0, 32'h002F_74C6, 32'h1000_0000 | (xs() & 32'hFFFF),
			32'h2000_0000 | (xs() & 32'hFFFC), 16'h2 + 16'(xs() % 8));
		apb_x(1'b1, ca(3'h0, 4'h0), 32'h002F_74C7);
		drain();
		rdc(12'h000, 32'h7);
		chk("irq0", irq[0], 1'b1);
		apb_x(1'b1, 12'h004, 32'h0);
		rdc(12'h000, 32'h7);
		apb_x(1'b1, 12'h004, 32'h2);
		rdc(12'h000, 32'h5);
		apb_x(1'b1, 12'h004, 32'h1);
		rdc(12'h000, 32'h0);
		chk("irq0", irq[0], 1'b0);
		run(3'h1, 32'h002F_4008, 32'hE000_0000, 32'h2000_0100, 16'h2);
		expq.delete();
		apb_x(1'b1, ca(3'h1, 4'h0), 32'h002F_4009);
		n = 0;
		while (irq[1] !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk("irq1", irq[1], 1'b1);
		rdc(12'h000, 32'h90);
		rdc(ca(3'h1, 4'h0), 32'h002F_4008);
		apb_x(1'b1, 12'h004, 32'h10);
		rdc(12'h000, 32'h0);
		run(3'h2, 32'h0001_1280, 32'h4000_0010, 32'h2000_0200 | (xs() & 32'hFFF), 16'h3);
		apb_x(1'b1, ca(3'h2, 4'h0), 32'h0001_1281);
		apb_x(1'b1, ca(3'h2, 4'h8), 32'h4000_0FF0);
		rdc(ca(3'h2, 4'h8), 32'h4000_0010);
		apb_x(1'b1, ca(3'h2, 4'h0), 32'h0001_12A1);
		rdc(ca(3'h2, 4'h0), 32'h0001_1281);
		want <= 1'b1;
		drain();
		rdc(12'h000, 32'h700);
		chk("irq2", irq[2], 1'b0);
		run(3'h3, 32'h000D_26D0, 32'h4000_0100, 32'h2000_0400 | (xs() & 32'hFFC),
			16'h2 + 16'(xs() % 8));
		apb_x(1'b1, ca(3'h3, 4'h0), 32'h000D_26D1);
		drain();
		want <= 1'b0;
		rdc(12'h000, 32'h7000);
		run(3'h4, 32'h0002_09A0, 32'h4000_0020, 32'h2000_0800 | (xs() & 32'hFFC), 16'h2);
		apb_x(1'b1, ca(3'h4, 4'h0), 32'h0002_09A1);
		want <= 1'b1;
		drain();
		want <= 1'b0;
		rdc(12'h000, 32'h0007_0000);
		rdc(ca(3'h4, 4'h4), 32'h2);
		end_of_test();
	end
endmodule : tb_top
